// >>> rtl/smi_host_port.sv
// Host-port decode, modem pins and serial interrupt pins for two serial channels
module smi_host_port
	import smi_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic read_strobe_n_in,
	input wire logic write_strobe_n_in,
	input wire logic select_channel_one_n_in,
	input wire logic select_channel_two_n_in,
	input wire logic select_printer_port_n_in,
	input wire logic [2:0] register_select_lines_in,
	input wire logic [7:0] host_data_bus_in,
	input wire logic [1:0] carrier_detect_in,
	input wire logic [1:0] ring_indicator_in,
	input wire logic [1:0] set_ready_in,
	input wire logic [1:0] clear_to_send_in,
	input wire logic [1:0] rx_error_in,
	input wire logic [1:0] rx_data_avail_in,
	input wire logic [1:0] thr_empty_in,
	output logic [7:0] host_data_bus_out,
	output logic host_data_bus_oe_n_out,
	output logic [1:0] terminal_ready_n_out,
	output logic [1:0] request_to_send_n_out,
	output logic channel_one_irq_out,
	output logic channel_one_irq_oe_n_out,
	output logic channel_two_irq_out,
	output logic channel_two_irq_oe_n_out,
	output logic printer_write_pulse_out,
	output logic printer_read_active_out
);

	// Strobe history and latched read selection
	logic rd_n_r, rd_n_nxt;
	logic wr_n_r, wr_n_nxt;
	logic [1:0] rd_sel_r, rd_sel_nxt;
	logic [2:0] rd_addr_r, rd_addr_nxt;

	// Registered pin drivers
	logic [7:0] dbus_r, dbus_nxt;
	logic dbus_oe_n_r, dbus_oe_n_nxt;
	logic [1:0] term_ready_n_r, term_ready_n_nxt;
	logic [1:0] req_send_n_r, req_send_n_nxt;
	logic [1:0] irq_r, irq_nxt;
	logic [1:0] irq_oe_n_r, irq_oe_n_nxt;
	logic prt_wr_r, prt_wr_nxt;
	logic prt_rd_r, prt_rd_nxt;

	// Decoded selects and per-channel wiring
	logic [1:0] chan_sel;
	logic prt_sel;
	logic wr_edge;
	logic rd_end;
	logic [1:0] chan_wr;
	logic [1:0] sts_done;
	logic [7:0] chan_rdata [2];
	logic [SMI_CTL_W-1:0] chan_ctl [2];
	logic [1:0] chan_irq;
	smi_modem_t chan_modem [2];
	smi_irq_src_t chan_src [2];

	// Chip-select decode; overlapping selects resolve to the lowest unit
	always_comb begin
		chan_sel[0] = !select_channel_one_n_in;
		chan_sel[1] = select_channel_one_n_in && !select_channel_two_n_in;
		prt_sel = select_channel_one_n_in && select_channel_two_n_in && !select_printer_port_n_in;
	end

	// Strobe edges: a write acts once on its leading edge, a read ends on the rising edge
	assign wr_edge = wr_n_r && !write_strobe_n_in;
	assign rd_end = !rd_n_r && read_strobe_n_in;

	// Per-channel write pulses and status-read completion
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			chan_wr[i] = wr_edge && chan_sel[i];
			// Flags clear only after the host has seen them on the bus
			sts_done[i] = rd_end && rd_sel_r[i] && rd_addr_r == SMI_ADDR_STS;
		end
	end

	// Gather the modem pins and datapath sources per channel
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			chan_modem[i].carrier_detect = carrier_detect_in[i];
			chan_modem[i].ring_indicator = ring_indicator_in[i];
			chan_modem[i].set_ready = set_ready_in[i];
			chan_modem[i].clear_to_send = clear_to_send_in[i];
			chan_src[i].rx_error = rx_error_in[i];
			chan_src[i].thr_empty = thr_empty_in[i];
			chan_src[i].rx_data_avail = rx_data_avail_in[i];
		end
	end

	// Channel one register set
	smi_chan u_chan_one (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.wr_pulse_in(chan_wr[0]),
		.addr_in(register_select_lines_in),
		.wdata_in(host_data_bus_in),
		.sts_rd_done_in(sts_done[0]),
		.modem_in(chan_modem[0]),
		.src_in(chan_src[0]),
		.rdata_out(chan_rdata[0]),
		.ctl_out(chan_ctl[0]),
		.irq_req_out(chan_irq[0])
	);

	// Channel two register set
	smi_chan u_chan_two (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.wr_pulse_in(chan_wr[1]),
		.addr_in(register_select_lines_in),
		.wdata_in(host_data_bus_in),
		.sts_rd_done_in(sts_done[1]),
		.modem_in(chan_modem[1]),
		.src_in(chan_src[1]),
		.rdata_out(chan_rdata[1]),
		.ctl_out(chan_ctl[1]),
		.irq_req_out(chan_irq[1])
	);

	// Next values of the host bus side
	always_comb begin
		rd_n_nxt = read_strobe_n_in;
		wr_n_nxt = write_strobe_n_in;
		rd_sel_nxt = read_strobe_n_in ? 2'b00 : chan_sel;
		rd_addr_nxt = register_select_lines_in;
		dbus_nxt = 8'h00;
		dbus_oe_n_nxt = 1'b1;
		// Data follows the address every cycle the strobe stays low
		if (!read_strobe_n_in && chan_sel[0]) begin
			dbus_nxt = chan_rdata[0];
			dbus_oe_n_nxt = 1'b0;
		end else if (!read_strobe_n_in && chan_sel[1]) begin
			dbus_nxt = chan_rdata[1];
			dbus_oe_n_nxt = 1'b0;
		end
		// Printer port registers live elsewhere; only its strobes are passed on
		prt_wr_nxt = wr_edge && prt_sel;
		prt_rd_nxt = !read_strobe_n_in && prt_sel;
	end

	// Bus side registers; the data bus floats out of reset
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			rd_sel_r <= 2'b00;
			rd_addr_r <= 3'h0;
			dbus_r <= 8'h00;
			dbus_oe_n_r <= 1'b1;
			prt_wr_r <= 1'b0;
			prt_rd_r <= 1'b0;
		end else begin
			rd_n_r <= rd_n_nxt;
			wr_n_r <= wr_n_nxt;
			rd_sel_r <= rd_sel_nxt;
			rd_addr_r <= rd_addr_nxt;
			dbus_r <= dbus_nxt;
			dbus_oe_n_r <= dbus_oe_n_nxt;
			prt_wr_r <= prt_wr_nxt;
			prt_rd_r <= prt_rd_nxt;
		end
	end

	// Next values of the modem and interrupt pins
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			term_ready_n_nxt[i] = !chan_ctl[i][SMI_CTL_TERM_READY];
			req_send_n_nxt[i] = !chan_ctl[i][SMI_CTL_REQ_SEND];
			// Value held low when not driven, so a later enable never glitches high
			irq_nxt[i] = chan_irq[i] && chan_ctl[i][SMI_CTL_IRQ_EN];
			irq_oe_n_nxt[i] = !chan_ctl[i][SMI_CTL_IRQ_EN];
		end
	end

	// Modem and interrupt pin registers; reset idles every driven line
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			term_ready_n_r <= 2'b11;
			req_send_n_r <= 2'b11;
			irq_r <= 2'b00;
			irq_oe_n_r <= 2'b11;
		end else begin
			term_ready_n_r <= term_ready_n_nxt;
			req_send_n_r <= req_send_n_nxt;
			irq_r <= irq_nxt;
			irq_oe_n_r <= irq_oe_n_nxt;
		end
	end

	// Output wiring straight from the flip-flops
	assign host_data_bus_out = dbus_r;
	assign host_data_bus_oe_n_out = dbus_oe_n_r;
	assign terminal_ready_n_out = term_ready_n_r;
	assign request_to_send_n_out = req_send_n_r;
	assign channel_one_irq_out = irq_r[0];
	assign channel_one_irq_oe_n_out = irq_oe_n_r[0];
	assign channel_two_irq_out = irq_r[1];
	assign channel_two_irq_oe_n_out = irq_oe_n_r[1];
	assign printer_write_pulse_out = prt_wr_r;
	assign printer_read_active_out = prt_rd_r;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	// A held read of channel one: strobe low with its select for two cycles
	sequence s_read_one_held;
		(!read_strobe_n_in && !select_channel_one_n_in)[*2];
	endsequence

	// A leading write edge into channel one's control register
	sequence s_write_ctl_one;
		write_strobe_n_in ##1 (!write_strobe_n_in && !select_channel_one_n_in
			&& register_select_lines_in == SMI_ADDR_CTL);
	endsequence

	chk_read_drives_bus: assert property (s_read_one_held |-> !host_data_bus_oe_n_out
		&& host_data_bus_out == $past(chan_rdata[0]))
		else $error("held read did not drive the addressed register");
	chk_write_loads_ctl: assert property (s_write_ctl_one |=> chan_ctl[0] == $past(host_data_bus_in[SMI_CTL_W-1:0]))
		else $error("write did not load the control register");
	chk_printer_no_drive: assert property (prt_sel && !read_strobe_n_in |=> host_data_bus_oe_n_out)
		else $error("printer access drove the serial bus");
	chk_term_ready_pin: assert property (chan_ctl[0][SMI_CTL_TERM_READY] |=> !terminal_ready_n_out[0])
		else $error("terminal ready pin not asserted");
	chk_term_ready_idle: assert property (!chan_ctl[1][SMI_CTL_TERM_READY] |=> terminal_ready_n_out[1])
		else $error("terminal ready pin not idle");
	chk_req_send_pin: assert property (##1 request_to_send_n_out[0] == !$past(chan_ctl[0][SMI_CTL_REQ_SEND]))
		else $error("request to send pin does not follow control");
	chk_irq_float_off: assert property (!chan_ctl[0][SMI_CTL_IRQ_EN] |=> channel_one_irq_oe_n_out)
		else $error("interrupt pin driven while disabled");
	chk_irq_enabled_high: assert property (chan_irq[1] && chan_ctl[1][SMI_CTL_IRQ_EN]
		|=> channel_two_irq_out && !channel_two_irq_oe_n_out)
		else $error("enabled source did not raise interrupt");
	chk_irq_serviced_low: assert property ($fell(chan_irq[0]) |=> !channel_one_irq_out)
		else $error("interrupt held after service");

endmodule

// >>> rtl/smi_pkg.sv
// Constants and carrier types for the serial host-port, modem and interrupt block
package smi_pkg;

	// Register offsets within one serial channel
	localparam logic [2:0] SMI_ADDR_IER = 3'h1;
	localparam logic [2:0] SMI_ADDR_CTL = 3'h4;
	localparam logic [2:0] SMI_ADDR_STS = 3'h6;

	// Register widths and reset values
	localparam int SMI_CTL_W = 5;
	localparam int SMI_IER_W = 4;
	localparam logic [SMI_CTL_W-1:0] SMI_CTL_RST = 5'h00;
	localparam logic [SMI_IER_W-1:0] SMI_IER_RST = 4'h0;
	localparam logic [3:0] SMI_FLAGS_CLR = 4'h0;

	// Control register fields
	localparam int SMI_CTL_TERM_READY = 0;
	localparam int SMI_CTL_REQ_SEND = 1;
	localparam int SMI_CTL_IRQ_EN = 3;

	// Interrupt enable fields
	localparam int SMI_IER_RX_AVAIL = 0;
	localparam int SMI_IER_THR_EMPTY = 1;
	localparam int SMI_IER_RX_ERROR = 2;
	localparam int SMI_IER_MODEM = 3;

	// Position of the ring indicator inside the modem input vector
	localparam int SMI_MOD_RING = 2;

	// Modem inputs in status-bit order: upper nibble of the status register
	typedef struct packed {
		logic carrier_detect;
		logic ring_indicator;
		logic set_ready;
		logic clear_to_send;
	} smi_modem_t;

	// Interrupt sources coming from the character datapath
	typedef struct packed {
		logic rx_error;
		logic thr_empty;
		logic rx_data_avail;
	} smi_irq_src_t;

endpackage

// >>> rtl/smi_chan.sv
// One serial channel: modem control, modem status and interrupt enable registers
module smi_chan
	import smi_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic wr_pulse_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic sts_rd_done_in,
	input wire smi_modem_t modem_in,
	input wire smi_irq_src_t src_in,
	output logic [7:0] rdata_out,
	output logic [SMI_CTL_W-1:0] ctl_out,
	output logic irq_req_out
);

	logic [SMI_CTL_W-1:0] modem_control_reg_r, modem_control_reg_nxt;
	logic [SMI_IER_W-1:0] ier_r, ier_nxt;
	logic [3:0] level_r, level_nxt;
	logic [3:0] flags_r, flags_nxt;
	logic primed_r, primed_nxt;
	logic [3:0] change;
	logic [SMI_IER_W-1:0] active;

	// Next-state: writes, samples and change flags
	always_comb begin
		modem_control_reg_nxt = modem_control_reg_r;
		ier_nxt = ier_r;
		if (wr_pulse_in && addr_in == SMI_ADDR_CTL) begin
			modem_control_reg_nxt = wdata_in[SMI_CTL_W-1:0];
		end
		if (wr_pulse_in && addr_in == SMI_ADDR_IER) begin
			ier_nxt = wdata_in[SMI_IER_W-1:0];
		end
		level_nxt = modem_in;
		primed_nxt = 1'b1;
		// First sample after reset is only a baseline, so no false change is flagged
		change = primed_r ? (level_r ^ modem_in) : 4'h0;
		change[SMI_MOD_RING] = primed_r & level_r[SMI_MOD_RING] & ~modem_in[SMI_MOD_RING];
		// Set wins over the end-of-read clear
		flags_nxt = (sts_rd_done_in ? SMI_FLAGS_CLR : flags_r) | change;
	end

	// State registers
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			modem_control_reg_r <= SMI_CTL_RST;
			ier_r <= SMI_IER_RST;
			level_r <= SMI_FLAGS_CLR;
			flags_r <= SMI_FLAGS_CLR;
			primed_r <= 1'b0;
		end else begin
			modem_control_reg_r <= modem_control_reg_nxt;
			ier_r <= ier_nxt;
			level_r <= level_nxt;
			flags_r <= flags_nxt;
			primed_r <= primed_nxt;
		end
	end

	// Read mux; unmapped offsets belong to the datapath and read zero here
	always_comb begin
		unique case (addr_in)
			SMI_ADDR_STS: rdata_out = {level_r, flags_r};
			SMI_ADDR_CTL: rdata_out = {{(8-SMI_CTL_W){1'b0}}, modem_control_reg_r};
			SMI_ADDR_IER: rdata_out = {{(8-SMI_IER_W){1'b0}}, ier_r};
			default: rdata_out = 8'h00;
		endcase
	end

	// Pending sources; datapath sources clear when the host services them
	assign active = {|flags_r, src_in.rx_error, src_in.thr_empty, src_in.rx_data_avail};
	assign irq_req_out = |(active & ier_r);
	assign ctl_out = modem_control_reg_r;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	chk_carrier_change_flag: assert property (primed_r && modem_in.carrier_detect != level_r[3] |=> flags_r[3])
		else $error("carrier change not flagged");
	chk_ring_trailing_edge: assert property (primed_r && level_r[SMI_MOD_RING] && !modem_in.ring_indicator
		|=> flags_r[SMI_MOD_RING])
		else $error("ring falling edge not flagged");
	chk_flags_clear_read: assert property (sts_rd_done_in && level_r == modem_in |=> flags_r == SMI_FLAGS_CLR)
		else $error("change flags not cleared by status read");
	chk_status_level: assert property (##1 rdata_out[7:4] == $past(modem_in) || addr_in != SMI_ADDR_STS)
		else $error("status upper nibble does not follow inputs");
	chk_modem_irq_source: assert property (|flags_r && ier_r[SMI_IER_MODEM] |-> irq_req_out)
		else $error("modem change did not request interrupt");

endmodule

// >>> verif/smi_modem_model.sv
// Modem-side model: holds the four handshake lines of both channels
module smi_modem_model (
	input wire logic clock_in,
	input wire logic [7:0] flip_in,
	output logic [1:0] cd_out,
	output logic [1:0] ring_out,
	output logic [1:0] dsr_out,
	output logic [1:0] cts_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines start idle high; a real modem only moves them at its own pace
	initial {cd_out, ring_out, dsr_out, cts_out} = 8'hff;

	// Each bit of flip_in toggles one line at the edge, so any edge pattern can be forced
	always @(posedge clock_in) begin
		{cd_out, ring_out, dsr_out, cts_out} <= {cd_out, ring_out, dsr_out, cts_out} ^ flip_in;
	end
endmodule

// >>> verif/tb_smi_host_port.sv
// Self-checking bench for the serial host-port, modem and interrupt block
module tb_smi_host_port
	import smi_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [2:0] sel_n = 3'h7;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] flip = 8'h00;
	logic [1:0] rx_err = 2'h0;
	logic [1:0] rx_av = 2'h0;
	logic [1:0] thr = 2'h0;
	logic [7:0] bus_q;
	logic bus_oe_n, irq1, irq1_oe_n, irq2, irq2_oe_n, pw, pr;
	logic [1:0] trn, rts, cd, ring, dsr, cts;
	int err_total = 0;
	int check_count = 0;
	int pw_cnt = 0;
	int ctl_ref[2], ier[2], flg[2], prev[2];

	initial forever #4 clock_in = ~clock_in;

	smi_host_port i_smi_host_port (.clock_in(clock_in), .rst_b_in(rst_b_in), .read_strobe_n_in(rd_n),
		.write_strobe_n_in(wr_n), .select_channel_one_n_in(sel_n[0]), .select_channel_two_n_in(sel_n[1]),
		.select_printer_port_n_in(sel_n[2]), .register_select_lines_in(addr), .host_data_bus_in(wdata),
		.carrier_detect_in(cd), .ring_indicator_in(ring), .set_ready_in(dsr), .clear_to_send_in(cts),
		.rx_error_in(rx_err), .rx_data_avail_in(rx_av), .thr_empty_in(thr), .host_data_bus_out(bus_q),
		.host_data_bus_oe_n_out(bus_oe_n), .terminal_ready_n_out(trn), .request_to_send_n_out(rts),
		.channel_one_irq_out(irq1), .channel_one_irq_oe_n_out(irq1_oe_n), .channel_two_irq_out(irq2),
		.channel_two_irq_oe_n_out(irq2_oe_n), .printer_write_pulse_out(pw), .printer_read_active_out(pr));

	smi_modem_model i_smi_modem_model (.clock_in(clock_in), .flip_in(flip), .cd_out(cd), .ring_out(ring),
		.dsr_out(dsr), .cts_out(cts));

	function automatic int pins(int c);
		return {cd[c], ring[c], dsr[c], cts[c]};
	endfunction

	// Reference change flags: any change of cd, dsr, cts; ring only on its falling edge
	always @(posedge clock_in) begin
		for (int c = 0; c < 2; c++) begin
			if (rst_b_in !== 1'b1) flg[c] = 0;
			else flg[c] |= ((pins(c) ^ prev[c]) & 'hb) | (prev[c] & ~pins(c) & 'h4);
			prev[c] = pins(c);
		end
		if (pw === 1'b1) pw_cnt++;
	end

	task automatic chk_byte(string what, int exp, logic [7:0] got);
		check_count++;
		if (got !== exp[7:0]) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp[7:0], got);
		end
	endtask

	task automatic chk_pin(string what, int exp, logic got);
		check_count++;
		if (got !== exp[0]) begin
			err_total++;
			$display("mismatch %s expected %b seen %b", what, exp[0], got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One bus cycle to unit c (2 printer, 3 both channels at once); strobe held three edges, then a gap
	task automatic access(logic wr, int c, logic [2:0] a, logic [7:0] d, output logic [7:0] q,
		output logic oe_n, output logic pra);
		@(posedge clock_in);
		sel_n <= (c == 3) ? 3'h4 : ~(3'h1 << c);
		addr <= a;
		wdata <= d;
		if (wr) wr_n <= 1'b0;
		else rd_n <= 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
		q = bus_q;
		oe_n = bus_oe_n;
		pra = pr;
		@(posedge clock_in);
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		sel_n <= 3'h7;
		repeat (2) @(posedge clock_in);
		#1 chk_pin("bus_release", 1, bus_oe_n);
		// Overlapping selects land in channel one only
		if (wr && c != 2 && a == SMI_ADDR_CTL) ctl_ref[c % 3] = d & 'h1f;
		if (wr && c != 2 && a == SMI_ADDR_IER) ier[c % 3] = d & 'hf;
		if (!wr && c != 2 && a == SMI_ADDR_STS) flg[c % 3] = 0;
	endtask

	task automatic chk_irq(int c, string what);
		int src;
		repeat (4) @(posedge clock_in);
		#1;
		src = {flg[c] != 0, rx_err[c], thr[c], rx_av[c]};
		chk_pin(what, ctl_ref[c][3] && (src & ier[c]) != 0, c ? irq2 : irq1);
		chk_pin("irq_oe_n", !ctl_ref[c][3], c ? irq2_oe_n : irq1_oe_n);
	endtask

	// Pins, registers and interrupt of one channel against the model
	task automatic check_chan(int c);
		logic [7:0] q;
		logic oe, pa;
		int exp;
		logic [2:0] spare[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
		chk_irq(c, "irq");
		chk_pin("terminal_ready_n", !ctl_ref[c][0], trn[c]);
		chk_pin("request_to_send_n", !ctl_ref[c][1], rts[c]);
		exp = (pins(c) << 4) | flg[c];
		access(1'b0, c, SMI_ADDR_STS, 8'h00, q, oe, pa);
		chk_byte("modem_status", exp, q);
		chk_pin("bus_drive", 0, oe);
		access(1'b0, c, SMI_ADDR_CTL, 8'h00, q, oe, pa);
		chk_byte("modem_control", ctl_ref[c], q);
		access(1'b0, c, SMI_ADDR_IER, 8'h00, q, oe, pa);
		chk_byte("ier", ier[c], q);
		access(1'b0, c, spare[$urandom % 5], 8'h00, q, oe, pa);
		chk_byte("spare", 0, q);
		chk_irq(c, "irq_after_read");
	endtask

	// Reset with the modem still; the modem control pins and all three output enables must sit at their idle levels meanwhile
	task automatic do_reset();
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		#1 chk_byte("reset_pins", 'hfe, {trn, rts, irq1_oe_n, irq2_oe_n, bus_oe_n, 1'b0});
		ctl_ref = '{0, 0};
		ier = '{0, 0};
		@(posedge clock_in);
		rst_b_in <= 1'b1;
	endtask

	initial begin
		logic [7:0] q;
		logic oe, pa;
		int n, c;
		void'($urandom(83122));
		do_reset();
		for (int r = 0; r < 24; r++) begin
			c = r % 2;
			n = pw_cnt;
			// Random modem activity, then the lines freeze before anything is read
			repeat (12) begin
				@(posedge clock_in);
				flip <= ($urandom % 3 == 0) ? 8'h01 << ($urandom % 8) : 8'h00;
			end
			@(posedge clock_in);
			flip <= 8'h00;
			{rx_err, rx_av, thr} <= 6'($urandom);
			access(1'b1, c ? c : 3, SMI_ADDR_CTL, 8'($urandom), q, oe, pa);
			access(1'b1, c, SMI_ADDR_IER, 8'($urandom), q, oe, pa);
			access(1'b1, c, SMI_ADDR_STS, 8'($urandom), q, oe, pa);
			access(1'b1, 2, SMI_ADDR_CTL, 8'($urandom), q, oe, pa);
			chk_byte("printer_pulses", n + 1, 8'(pw_cnt));
			access(1'b0, 2, SMI_ADDR_CTL, 8'h00, q, oe, pa);
			chk_pin("printer_read_oe_n", 1, oe);
			chk_pin("printer_read", 1, pa);
			check_chan(0);
			check_chan(1);
		end
		// A second reset mid-run must idle outputs and clear control state
		do_reset();
		check_chan(0);
		check_chan(1);
		print_verdict();
	end

	// Run needs roughly 21 us; a generous limit cuts a hang short
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
endmodule
